//--- ablc_pkg.sv
// Constants and decode helpers for the adaptive backlight settings command
package ablc_pkg;

  // ----------------------------------------------------------------
  // Command code and parameter layout
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_ADAPTIVE_LIGHT = 8'hB8;
  localparam int         PARAM_COUNT        = 16;

  localparam logic [3:0] IDX_ENABLE  = 4'h0;
  localparam logic [3:0] IDX_RATIO_A = 4'h1;
  localparam logic [3:0] IDX_RATIO_B = 4'h2;
  localparam logic [3:0] IDX_UPPER_A = 4'h3;
  localparam logic [3:0] IDX_UPPER_B = 4'h4;
  localparam logic [3:0] IDX_LOWER_A = 4'h5;
  localparam logic [3:0] IDX_LOWER_B = 4'h6;
  localparam logic [3:0] IDX_PITCH   = 4'h7;
  localparam logic [3:0] IDX_GAP     = 4'h8;
  localparam logic [3:0] IDX_COEF_A  = 4'h9;
  localparam logic [3:0] IDX_COEF_B  = 4'hA;
  localparam logic [3:0] IDX_CURVE3  = 4'hB;
  localparam logic [3:0] IDX_CURVE4  = 4'hC;
  localparam logic [3:0] IDX_CURVE5  = 4'hD;
  localparam logic [3:0] IDX_CURVE6  = 4'hE;
  localparam logic [3:0] IDX_TAIL    = 4'hF;

  // ----------------------------------------------------------------
  // Field positions, writable masks and reset value
  // ----------------------------------------------------------------
  localparam int         ON_BIT       = 0;
  localparam int         MODE_BIT     = 1;
  localparam int         LINCOMP_BIT  = 7;
  localparam logic [7:0] MASK_ENABLE  = 8'h03;
  localparam logic [7:0] MASK_RATIO   = 8'h1F;
  localparam logic [7:0] MASK_FULL    = 8'hFF;
  localparam logic [7:0] MASK_PITCH   = 8'h0F;
  localparam logic [7:0] MASK_GAP     = 8'h1F;
  localparam logic [7:0] MASK_COEF    = 8'h9F;
  localparam logic [7:0] MASK_TAIL    = 8'h00;
  localparam logic [7:0] PARAM_RESET  = 8'h00;
  localparam int         PCT_PER_CODE = 2;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_ACCESS = 2'b01,
    ST_DONE   = 2'b10
  } cmd_state_e;

  // Bits that each parameter byte really holds; the rest read zero
  function automatic logic [7:0] param_mask(input logic [3:0] idx);
    case (idx)
      IDX_ENABLE:               param_mask = MASK_ENABLE;
      IDX_RATIO_A, IDX_RATIO_B: param_mask = MASK_RATIO;
      IDX_PITCH:                param_mask = MASK_PITCH;
      IDX_GAP:                  param_mask = MASK_GAP;
      IDX_COEF_A, IDX_COEF_B:   param_mask = MASK_COEF;
      IDX_TAIL:                 param_mask = MASK_TAIL;
      default:                  param_mask = MASK_FULL;
    endcase
  endfunction

endpackage

//--- ablc_param_store.sv
// Sixteen masked parameter bytes of the adaptive backlight command
`timescale 1ns/1ps
module ablc_param_store (
  input  wire logic                                    mclk_i,
  input  wire logic                                    sys_rst_i,
  input  wire logic                                    wr_en_i,
  input  wire logic [3:0]                              wr_idx_i,
  input  wire logic [7:0]                              wr_data_i,
  output logic      [ablc_pkg::PARAM_COUNT-1:0][7:0]   bytes_o
);
  import ablc_pkg::*;

  logic [7:0] param_reg [PARAM_COUNT];

  // ----------------------------------------------------------------
  // One register per parameter byte
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < PARAM_COUNT; g++) begin : g_byte
      localparam logic [3:0] IDX = 4'(g);
      // Unused bits are never stored, so they always read zero
      always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
          param_reg[g] <= PARAM_RESET;
        end else if (wr_en_i && wr_idx_i == IDX) begin
          param_reg[g] <= wr_data_i & param_mask(IDX); // see R08
        end
      end
      assign bytes_o[g] = param_reg[g];
    end
  endgenerate

endmodule // ablc_param_store

//--- ablc_regs.sv
// Command decode, parameter access and mode selection for adaptive backlight
// What this block and its host do
// R01: Command B8h opens sixteen parameter bytes, written and read back by host.
// R02: Bit 0 of first parameter switches the adaptive function on or off.
// R03: Bit 1 of first parameter selects set 0 or set 1; pitch, gap shared.
// R04: Two independent copies of ratio, caps, floors, coefficient and compensation.
// R05: Host clears the on bit before changing parameters or mode.
// R06: Host always writes zero to the sixteenth parameter byte.
// R07: Function active only when on, normal mode on and inversion off.
// R08: Field widths 5, 8, 4, 5 bits; coefficient bit 7 compensation; unused zero.
// R09: Ratio code means twice its value in percent, zero to 62.
// R10: Upper cap limits the computed threshold grayscale, one grayscale per step.
// R11: Lower floor raises the computed threshold grayscale, one grayscale per step.
`timescale 1ns/1ps
module ablc_regs (
  input  wire logic       mclk_i,
  input  wire logic       sys_rst_i,
  input  wire logic       host_wr_i,
  input  wire logic       host_rd_i,
  input  wire logic       command_or_param_sel_i,
  input  wire logic [7:0] host_data_i,
  output logic      [7:0] host_data_o,
  output logic            host_data_oe_o,
  input  wire logic       normal_mode_i,
  input  wire logic       invert_on_i,
  input  wire logic [7:0] computed_level_i,
  output logic            function_active_o,
  output logic            adaptive_light_mode_sel_o,
  output logic      [4:0] white_ratio_o,
  output logic      [5:0] white_ratio_pct_o,
  output logic      [7:0] upper_cap_o,
  output logic      [7:0] lower_floor_o,
  output logic      [4:0] gain_coef_o,
  output logic            linear_comp_o,
  output logic      [3:0] step_pitch_o,
  output logic      [4:0] change_gap_o,
  output logic      [7:0] curve_entry_three_o,
  output logic      [7:0] curve_entry_four_o,
  output logic      [7:0] curve_entry_five_o,
  output logic      [7:0] curve_entry_six_o,
  output logic      [7:0] clamped_level_o
);
  import ablc_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic       wr_s1_reg, wr_s2_reg, wr_s3_reg;
  logic       rd_s1_reg, rd_s2_reg, rd_s3_reg;
  logic       sel_s1_reg, sel_s2_reg;
  logic [7:0] dat_s1_reg, dat_s2_reg;

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      {wr_s1_reg, wr_s2_reg, wr_s3_reg}  <= 3'h0;
      {rd_s1_reg, rd_s2_reg, rd_s3_reg}  <= 3'h0;
      {sel_s1_reg, sel_s2_reg}           <= 2'h0;
      {dat_s1_reg, dat_s2_reg}           <= 16'h0000;
    end else begin
      {wr_s3_reg, wr_s2_reg, wr_s1_reg}  <= {wr_s2_reg, wr_s1_reg, host_wr_i};
      {rd_s3_reg, rd_s2_reg, rd_s1_reg}  <= {rd_s2_reg, rd_s1_reg, host_rd_i};
      {sel_s2_reg, sel_s1_reg}           <= {sel_s1_reg, command_or_param_sel_i};
      {dat_s2_reg, dat_s1_reg}           <= {dat_s1_reg, host_data_i};
    end
  end

  // Strobes act on their rising edge; data and select must be steady by then
  wire wr_edge   = wr_s2_reg & ~wr_s3_reg;
  wire rd_edge   = rd_s2_reg & ~rd_s3_reg;
  wire cmd_wr    = wr_edge & ~sel_s2_reg;
  wire param_wr  = wr_edge & sel_s2_reg;
  wire param_rd  = rd_edge & sel_s2_reg;

  // ----------------------------------------------------------------
  // Command state and parameter index
  // ----------------------------------------------------------------
  cmd_state_e state_reg, state_next;
  logic [3:0] param_idx_reg, param_idx_next;
  logic [7:0] rd_data_reg, rd_data_next;
  logic [PARAM_COUNT-1:0][7:0] bytes;

  wire in_access = (state_reg == ST_ACCESS);
  wire store_wr  = param_wr & in_access;
  wire step_idx  = (param_wr | param_rd) & in_access;
  wire [7:0] rd_byte = bytes[param_idx_reg];

  always_comb begin
    state_next     = state_reg;
    param_idx_next = param_idx_reg;
    rd_data_next   = rd_data_reg;
    case (state_reg)
      ST_IDLE, ST_DONE: begin
        if (param_rd) begin
          rd_data_next = PARAM_RESET;
        end
      end
      ST_ACCESS: begin
        if (param_rd) begin
          rd_data_next = rd_byte; // see R01
        end
        if (step_idx) begin
          param_idx_next = param_idx_reg + 4'h1;
          if (param_idx_reg == IDX_TAIL) begin
            state_next = ST_DONE;
          end
        end
      end
      default: state_next = ST_IDLE;
    endcase
    // A new command code always restarts decoding
    if (cmd_wr) begin
      param_idx_next = IDX_ENABLE;
      state_next     = (dat_s2_reg == CMD_ADAPTIVE_LIGHT) ? ST_ACCESS : ST_IDLE; // see R01
    end
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_reg     <= ST_IDLE;
      param_idx_reg <= 4'h0;
      rd_data_reg   <= 8'h00;
    end else begin
      state_reg     <= state_next;
      param_idx_reg <= param_idx_next;
      rd_data_reg   <= rd_data_next;
    end
  end

  assign host_data_o    = rd_data_reg;
  assign host_data_oe_o = rd_s2_reg & sel_s2_reg;

  // The sixteenth byte is stored masked to zero whatever the host writes; see R06
  ablc_param_store u_store (
    .mclk_i    (mclk_i),
    .sys_rst_i (sys_rst_i),
    .wr_en_i   (store_wr),
    .wr_idx_i  (param_idx_reg),
    .wr_data_i (dat_s2_reg),
    .bytes_o   (bytes)
  );

  // ----------------------------------------------------------------
  // Mode selection and clamp
  // ----------------------------------------------------------------
  // Settings switch live; the host keeps the function off while changing them, see R05
  wire       mode_sel  = bytes[IDX_ENABLE][MODE_BIT];
  wire       on_bit    = bytes[IDX_ENABLE][ON_BIT];
  wire [7:0] ratio_sel = mode_sel ? bytes[IDX_RATIO_B] : bytes[IDX_RATIO_A]; // see R03
  wire [7:0] upper_sel = mode_sel ? bytes[IDX_UPPER_B] : bytes[IDX_UPPER_A]; // see R04
  wire [7:0] lower_sel = mode_sel ? bytes[IDX_LOWER_B] : bytes[IDX_LOWER_A]; // see R04
  wire [7:0] coef_sel  = mode_sel ? bytes[IDX_COEF_B]  : bytes[IDX_COEF_A];  // see R04
  wire [5:0] pct_calc  = 6'(ratio_sel[4:0] * PCT_PER_CODE);                 // see R09
  // Cap first, floor last: a floor above the cap wins
  wire [7:0] capped    = (computed_level_i > upper_sel) ? upper_sel : computed_level_i; // see R10
  wire [7:0] floored   = (capped < lower_sel) ? lower_sel : capped;                     // see R11
  wire       active    = on_bit & normal_mode_i & ~invert_on_i; // see R02 see R07

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      function_active_o         <= 1'b0;
      adaptive_light_mode_sel_o <= 1'b0;
      white_ratio_o             <= 5'h00;
      white_ratio_pct_o         <= 6'h00;
      upper_cap_o               <= 8'h00;
      lower_floor_o             <= 8'h00;
      gain_coef_o               <= 5'h00;
      linear_comp_o             <= 1'b0;
      step_pitch_o              <= 4'h0;
      change_gap_o              <= 5'h00;
      curve_entry_three_o       <= 8'h00;
      curve_entry_four_o        <= 8'h00;
      curve_entry_five_o        <= 8'h00;
      curve_entry_six_o         <= 8'h00;
      clamped_level_o           <= 8'h00;
    end else begin
      function_active_o         <= active;
      adaptive_light_mode_sel_o <= mode_sel;
      white_ratio_o             <= ratio_sel[4:0];
      white_ratio_pct_o         <= pct_calc;
      upper_cap_o               <= upper_sel;
      lower_floor_o             <= lower_sel;
      gain_coef_o               <= coef_sel[4:0];
      linear_comp_o             <= coef_sel[LINCOMP_BIT];
      step_pitch_o              <= bytes[IDX_PITCH][3:0];
      change_gap_o              <= bytes[IDX_GAP][4:0];
      curve_entry_three_o       <= bytes[IDX_CURVE3];
      curve_entry_four_o        <= bytes[IDX_CURVE4];
      curve_entry_five_o        <= bytes[IDX_CURVE5];
      curve_entry_six_o         <= bytes[IDX_CURVE6];
      clamped_level_o           <= floored;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_cmd_open: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // see R01
    cmd_wr && dat_s2_reg == CMD_ADAPTIVE_LIGHT |=> state_reg == ST_ACCESS && param_idx_reg == 4'h0)
    else $error("B8 command did not open parameter access");

  a_other_cmd: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // see R01
    cmd_wr && dat_s2_reg != CMD_ADAPTIVE_LIGHT |=> state_reg == ST_IDLE)
    else $error("foreign command left access open");

  a_param_store: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // see R08
    store_wr |=> bytes[$past(param_idx_reg)] == ($past(dat_s2_reg) & param_mask($past(param_idx_reg))))
    else $error("parameter byte not stored with its mask");

  a_idx_step: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // see R01
    step_idx && !cmd_wr && param_idx_reg != IDX_TAIL |=> param_idx_reg == $past(param_idx_reg) + 4'h1)
    else $error("parameter index did not advance");

  a_last_byte: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // see R01
    step_idx && !cmd_wr && param_idx_reg == IDX_TAIL |=> state_reg == ST_DONE)
    else $error("access not closed after sixteenth byte");

  a_read_back: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // see R01
    param_rd && in_access && !store_wr |=> host_data_o == $past(rd_byte))
    else $error("read back data mismatch");

  a_tail_zero: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // see R06
    bytes[IDX_TAIL] == 8'h00)
    else $error("sixteenth byte not zero");

  a_active_gate: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // see R07
    ##1 function_active_o == ($past(on_bit) && $past(normal_mode_i) && !$past(invert_on_i)))
    else $error("function active against its gate");

  a_invert_off: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // see R07
    invert_on_i [*2] |-> !function_active_o)
    else $error("function active during inversion");

  a_mode_ratio: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // see R03
    ##1 white_ratio_o == ($past(mode_sel) ? $past(bytes[IDX_RATIO_B][4:0])
                                          : $past(bytes[IDX_RATIO_A][4:0])))
    else $error("ratio from wrong set");

  a_pct_double: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // see R09
    white_ratio_pct_o == {white_ratio_o, 1'b0})
    else $error("percentage not twice the code");

  a_clamp_range: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // see R10
    lower_sel <= upper_sel |=> clamped_level_o <= $past(upper_sel)
                               && clamped_level_o >= $past(lower_sel))
    else $error("clamped level outside cap and floor");

  c_full_write: cover property (@(posedge mclk_i) disable iff (sys_rst_i)
    store_wr && param_idx_reg == IDX_TAIL ##1 state_reg == ST_DONE);
  c_mode_one: cover property (@(posedge mclk_i) disable iff (sys_rst_i)
    function_active_o && adaptive_light_mode_sel_o);
  c_read_back: cover property (@(posedge mclk_i) disable iff (sys_rst_i)
    param_rd && in_access && param_idx_reg == IDX_UPPER_A);
  c_clamped: cover property (@(posedge mclk_i) disable iff (sys_rst_i)
    computed_level_i > upper_sel && lower_sel <= upper_sel);

endmodule // ablc_regs

//--- ablc_host_model.sv
// Host processor model that drives the adaptive backlight command port
`timescale 1ns/1ps
module ablc_host_model (
  input  wire logic       mclk_i,
  input  wire logic [7:0] rd_data_i,
  output logic            wr_strobe_o,
  output logic            rd_strobe_o,
  output logic            sel_o,
  output logic      [7:0] data_o
);
  initial begin
    wr_strobe_o = 1'b0;
    rd_strobe_o = 1'b0;
    sel_o       = 1'b0;
    data_o      = 8'h5A;
  end
  // ------------------------------
  // Single strobe cycle
  // ------------------------------
  // Select and data lead the strobe by three clocks so the input synchroniser sees them steady
  task automatic access(input logic is_rd, input logic sel, input logic [7:0] d,
                        output logic [7:0] q);
    @(posedge mclk_i);
    #1;
    sel_o  = sel;
    data_o = d;
    repeat (3) @(posedge mclk_i);
    #1;
    if (is_rd) rd_strobe_o = 1'b1;
    else wr_strobe_o = 1'b1;
    repeat (5) @(posedge mclk_i);
    q = rd_data_i;
    #1;
    rd_strobe_o = 1'b0;
    wr_strobe_o = 1'b0;
    repeat (4) @(posedge mclk_i);
    #1;
    data_o = ~d;  // Released bus never shows the stale byte
  endtask
  // ------------------------------
  // Command sequences
  // ------------------------------
  task automatic load(input logic [7:0] b [16]);
    logic [7:0] q;
    access(1'b0, 1'b0, 8'hB8, q);
    access(1'b0, 1'b1, b[0] & 8'h02, q);
    for (int i = 1; i < 15; i++) access(1'b0, 1'b1, b[i], q);
    access(1'b0, 1'b1, 8'h00, q);
  endtask
  task automatic set_ctl(input logic [7:0] b);
    logic [7:0] q;
    access(1'b0, 1'b0, 8'hB8, q);
    access(1'b0, 1'b1, 8'h00, q);
    access(1'b0, 1'b0, 8'hB8, q);
    access(1'b0, 1'b1, b, q);
  endtask
  task automatic rd_block(output logic [7:0] q [17]);
    logic [7:0] x;
    access(1'b0, 1'b0, 8'hB8, x);
    for (int i = 0; i < 17; i++) access(1'b1, 1'b1, 8'h00, q[i]);
  endtask
endmodule // ablc_host_model

//--- ablc_regs_tb.sv
// Self-checking testbench for the adaptive backlight settings block
`timescale 1ns/1ps
module ablc_regs_tb;
  import ablc_pkg::*;
  logic       mclk_i, sys_rst_i, host_wr_i, host_rd_i, command_or_param_sel_i;
  logic       normal_mode_i, invert_on_i, function_active_o, host_data_oe_o;
  logic       adaptive_light_mode_sel_o, linear_comp_o;
  logic [7:0] host_data_i, host_data_o, computed_level_i, clamped_level_o;
  logic [7:0] upper_cap_o, lower_floor_o, curve_entry_three_o, curve_entry_four_o;
  logic [7:0] curve_entry_five_o, curve_entry_six_o;
  logic [4:0] white_ratio_o, gain_coef_o, change_gap_o;
  logic [5:0] white_ratio_pct_o;
  logic [3:0] step_pitch_o;
  int         fail_count   = 0;
  int         total_checks = 0;
  logic [7:0] q [17];
  logic [7:0] cfg [16] = '{8'h00, 8'h1F, 8'h05, 8'h80, 8'hC8, 8'h10, 8'h20, 8'h0A,
                           8'h15, 8'h9F, 8'h03, 8'h11, 8'h22, 8'h33, 8'h44, 8'h00};

  ablc_regs u_dut (.mclk_i, .sys_rst_i, .host_wr_i, .host_rd_i, .command_or_param_sel_i,
    .host_data_i, .host_data_o, .host_data_oe_o, .normal_mode_i, .invert_on_i,
    .computed_level_i, .function_active_o, .adaptive_light_mode_sel_o, .white_ratio_o,
    .white_ratio_pct_o, .upper_cap_o, .lower_floor_o, .gain_coef_o, .linear_comp_o,
    .step_pitch_o, .change_gap_o, .curve_entry_three_o, .curve_entry_four_o,
    .curve_entry_five_o, .curve_entry_six_o, .clamped_level_o);
  ablc_host_model u_host (.mclk_i, .rd_data_i(host_data_o), .wr_strobe_o(host_wr_i),
    .rd_strobe_o(host_rd_i), .sel_o(command_or_param_sel_i), .data_o(host_data_i));

  initial begin
    mclk_i = 1'b0;
    forever #2.5 mclk_i = ~mclk_i;
  end
  // ------------------------------
  // Shared helpers
  // ------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic complete_run;
    $display("checks=%0d mismatches=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk_set(input logic [7:0] e [7]);
    chk({7'h0, adaptive_light_mode_sel_o}, e[0]);
    chk({3'h0, white_ratio_o}, e[1]);
    chk({2'h0, white_ratio_pct_o}, e[2]);
    chk(upper_cap_o, e[3]);
    chk(lower_floor_o, e[4]);
    chk({3'h0, gain_coef_o}, e[5]);
    chk({7'h0, linear_comp_o}, e[6]);
    chk({4'h0, step_pitch_o}, 8'h0A);
    chk({3'h0, change_gap_o}, 8'h15);
    chk(curve_entry_three_o, 8'h11);
    chk(curve_entry_four_o, 8'h22);
    chk(curve_entry_five_o, 8'h33);
    chk(curve_entry_six_o, 8'h44);
  endtask
  // ------------------------------
  // Scenarios
  // ------------------------------
  task automatic t_reset;
    logic [7:0] x;
    chk(host_data_o, 8'h00);
    chk({7'h0, function_active_o}, 8'h00);
    chk({7'h0, host_data_oe_o}, 8'h00);
    fork
      u_host.access(1'b1, 1'b1, 8'h00, x);
      begin
        repeat (7) @(posedge mclk_i);
        #1;
        chk({7'h0, host_data_oe_o}, 8'h01);
      end
    join
    chk(x, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_readback;
    logic [7:0] f [16];
    logic [7:0] m [16];
    logic [7:0] x;
    m = '{8'h02, MASK_RATIO, MASK_RATIO, MASK_FULL, MASK_FULL, MASK_FULL, MASK_FULL,
          MASK_PITCH, MASK_GAP, MASK_COEF, MASK_COEF, MASK_FULL, MASK_FULL, MASK_FULL,
          MASK_FULL, MASK_TAIL};
    foreach (f[i]) f[i] = 8'hFF;
    u_host.load(f);
    u_host.rd_block(q);
    for (int i = 0; i < 16; i++) chk(q[i], m[i]);
    chk(q[16], 8'h00);
    u_host.access(1'b0, 1'b0, CMD_ADAPTIVE_LIGHT, x);
    u_host.access(1'b1, 1'b1, 8'h00, x);
    chk(x, 8'h02);
    // A foreign command closes access: its parameter is dropped and reads give zero
    u_host.access(1'b0, 1'b0, 8'h2C, x);
    u_host.access(1'b0, 1'b1, 8'hFF, x);
    u_host.access(1'b1, 1'b1, 8'h00, x);
    chk(x, 8'h00);
    u_host.access(1'b0, 1'b0, CMD_ADAPTIVE_LIGHT, x);
    u_host.access(1'b1, 1'b1, 8'h00, x);
    chk(x, 8'h02);
    $display("test readback done");
  endtask
  task automatic t_mode;
    u_host.load(cfg);
    u_host.set_ctl(8'h01);
    chk_set('{8'h00, 8'h1F, 8'h3E, 8'h80, 8'h10, 8'h1F, 8'h01});
    u_host.set_ctl(8'h03);
    chk_set('{8'h01, 8'h05, 8'h0A, 8'hC8, 8'h20, 8'h03, 8'h00});
    $display("test mode done");
  endtask
  task automatic t_active;
    for (int i = 0; i < 5; i++) begin
      if (i == 4) u_host.set_ctl(8'h02);
      @(posedge mclk_i);
      #1;
      normal_mode_i = (i == 4) ? 1'b1 : i[0];
      invert_on_i   = (i == 4) ? 1'b0 : i[1];
      repeat (2) @(posedge mclk_i);
      #1;
      chk({7'h0, function_active_o}, {7'h0, (i == 1)});
    end
    $display("test active done");
  endtask
  task automatic t_clamp;
    logic [7:0] lv [6] = '{8'h90, 8'hC8, 8'h40, 8'h20, 8'h05, 8'hFF};
    logic [7:0] ex [6] = '{8'h90, 8'hC8, 8'h40, 8'h20, 8'h20, 8'hC8};
    for (int i = 0; i < 6; i++) begin
      @(posedge mclk_i);
      #1;
      computed_level_i = lv[i];
      repeat (2) @(posedge mclk_i);
      #1;
      chk(clamped_level_o, ex[i]);
    end
    $display("test clamp done");
  endtask
  // Reset in mid-run must drop every loaded byte and output back to zero
  task automatic t_rerun_reset;
    logic [7:0] x;
    @(posedge mclk_i);
    #1;
    sys_rst_i = 1'b1;
    repeat (2) @(posedge mclk_i);
    #1;
    sys_rst_i = 1'b0;
    chk(upper_cap_o, 8'h00);
    chk(curve_entry_six_o, 8'h00);
    chk({7'h0, host_data_oe_o}, 8'h00);
    u_host.access(1'b0, 1'b0, CMD_ADAPTIVE_LIGHT, x);
    u_host.access(1'b1, 1'b1, 8'h00, x);
    chk(x, 8'h00);
    $display("test rerun reset done");
  endtask

  initial begin
    sys_rst_i        = 1'b1;
    normal_mode_i    = 1'b0;
    invert_on_i      = 1'b0;
    computed_level_i = 8'h00;
    repeat (2) @(posedge mclk_i);
    #1;
    sys_rst_i = 1'b0;
    t_reset();
    t_readback();
    t_mode();
    t_active();
    t_clamp();
    t_rerun_reset();
    complete_run();
  end
  // Run needs about 1000 clocks; the watchdog allows ample margin
  initial begin
    repeat (20000) @(posedge mclk_i);
    fail_count++;
    $display("watchdog expired at t=%0t", $time);
    complete_run();
  end
endmodule // ablc_regs_tb
